// File: verilog/link_retry_ctrl.sv
// link-layer retry, timeout and rts/cts sequencing for a serial port
// assumes an ahb-lite master on hclk and a framer that reports link events
// Summary of operation
// - error check is crc or block check, crc by default.
// - embed responses always, or only after peer embeds; latter by default.
// - on nak, resend the packet up to a set count, default 3.
// - after ack timeout, send enquiries up to a set count, default 3.
// - retry message 0 to 127 times, default 3, then flag undeliverable.
// - wait for ack a set number of 20 ms units, default 50.
// - slave with suppression on and nothing queued ignores polls; off by default.
// - pending slave message waits for poll, default 3000 units; zero disables.
// - hold rts after last character for a set delay, default 0.
// - after raising rts wait a set delay before sampling cts, default 0.
// - slave resends unacknowledged message up to 0 to 255 times, default 3.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
module link_retry_ctrl
  import link_retry_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial link side
  input wire link_evt_s link_evt,
  output link_ctl_s link_ctl
);

  // true while a retry counter still has attempts left
  function automatic logic has_left(input logic [7:0] cnt, input logic [7:0] lim);
    has_left = cnt < lim;
  endfunction : has_left

  // configuration registers
  logic [3:0] ctrl_q;
  logic [7:0] nak_lim_q;
  logic [7:0] enq_lim_q;
  logic [6:0] tx_lim_q;
  logic [7:0] msg_lim_q;
  logic [15:0] ack_tmo_q;
  logic [15:0] poll_tmo_q;
  logic [15:0] rts_off_q;
  logic [15:0] rts_send_q;

  // bus data-phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_mux;
  logic addr_ok;

  // sequencer state
  link_state_e state_q;
  logic [15:0] timer_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [7:0] nak_cnt_q;
  logic [7:0] enq_cnt_q;
  logic [7:0] retry_cnt_q;
  logic peer_embed_q;
  logic set_undeliv;
  logic set_msg_err;
  logic attempt_fail;
  logic [7:0] retry_lim;
  logic timer_done;

  assign addr_ok = hsel && htrans[1] && hready;
  assign timer_done = (timer_q == 16'h0000);
  assign retry_lim = ctrl_q[CTRL_SLAVE_BIT] ? msg_lim_q : {1'b0, tx_lim_q};

  // capture the address phase; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == OFS_CTRL) begin
      rd_mux[3:0] = ctrl_q;
    end else if (haddr[7:0] == OFS_RETRY) begin
      rd_mux = {msg_lim_q, 1'b0, tx_lim_q, enq_lim_q, nak_lim_q};
    end else if (haddr[7:0] == OFS_ACK_TMO) begin
      rd_mux[15:0] = ack_tmo_q;
    end else if (haddr[7:0] == OFS_POLL_TMO) begin
      rd_mux[15:0] = poll_tmo_q;
    end else if (haddr[7:0] == OFS_RTS_OFF) begin
      rd_mux[15:0] = rts_off_q;
    end else if (haddr[7:0] == OFS_RTS_SEND) begin
      rd_mux[15:0] = rts_send_q;
    end else if (haddr[7:0] == OFS_STATUS) begin
      rd_mux[STAT_UNDELIV_BIT] = link_ctl.undeliverable;
      rd_mux[STAT_MSG_ERR_BIT] = link_ctl.msg_error;
      rd_mux[STAT_EMBED_BIT] = link_ctl.embed_en;
      rd_mux[STAT_STATE_LSB +: 7] = state_q;
      rd_mux[31:24] = retry_cnt_q;
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
      nak_lim_q <= NAK_RETRY_RESET;
      enq_lim_q <= ENQ_RETRY_RESET;
      tx_lim_q <= TX_RETRY_RESET;
      msg_lim_q <= MSG_RETRY_RESET;
      ack_tmo_q <= ACK_TMO_RESET;
      poll_tmo_q <= POLL_TMO_RESET;
      rts_off_q <= RTS_OFF_RESET;
      rts_send_q <= RTS_SEND_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == OFS_CTRL) begin
        ctrl_q <= hwdata[3:0];
      end else if (wr_addr_q == OFS_RETRY) begin
        nak_lim_q <= hwdata[RETRY_NAK_LSB +: 8];
        enq_lim_q <= hwdata[RETRY_ENQ_LSB +: 8];
        tx_lim_q <= hwdata[RETRY_TX_LSB +: 7];
        msg_lim_q <= hwdata[RETRY_MSG_LSB +: 8];
      end else if (wr_addr_q == OFS_ACK_TMO) begin
        ack_tmo_q <= hwdata[15:0];
      end else if (wr_addr_q == OFS_POLL_TMO) begin
        poll_tmo_q <= hwdata[15:0];
      end else if (wr_addr_q == OFS_RTS_OFF) begin
        rts_off_q <= hwdata[15:0];
      end else if (wr_addr_q == OFS_RTS_SEND) begin
        rts_send_q <= hwdata[15:0];
      end
    end
  end

  // free-running 20 ms tick shared by all timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LEN - 1) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // peer embedding is remembered until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peer_embed_q <= 1'b0;
    end else if (link_evt.embed_seen) begin
      peer_embed_q <= 1'b1;
    end
  end

  // an attempt fails when nak or enquiry budgets run out
  always_comb begin
    attempt_fail = 1'b0;
    if (state_q == ST_ACK_WAIT) begin
      if (link_evt.ack_rx) begin
        attempt_fail = 1'b0;
      end else if (link_evt.nak_rx) begin
        attempt_fail = !has_left(nak_cnt_q, nak_lim_q);
      end else if (tick_q && timer_q == 16'h0001 || timer_done) begin
        attempt_fail = !has_left(enq_cnt_q, enq_lim_q);
      end
    end
  end

  assign set_undeliv = attempt_fail && !has_left(retry_cnt_q, retry_lim);
  assign set_msg_err = (state_q == ST_POLL_WAIT) && !link_evt.poll_rx && poll_tmo_q != 16'h0000
                       && (timer_done || tick_q && timer_q == 16'h0001);

  // link sequencer; timer is reloaded on entry to poll wait, rts wait, rts hold and ack wait, counts ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      timer_q <= 16'h0000;
      nak_cnt_q <= 8'h00;
      enq_cnt_q <= 8'h00;
      retry_cnt_q <= 8'h00;
    end else begin
      if (tick_q && !timer_done) begin
        timer_q <= timer_q - 16'h0001;
      end
      case (state_q)
        ST_IDLE: begin
          nak_cnt_q <= 8'h00;
          enq_cnt_q <= 8'h00;
          retry_cnt_q <= 8'h00;
          if (link_evt.msg_start && ctrl_q[CTRL_SLAVE_BIT]) begin
            state_q <= ST_POLL_WAIT;
            timer_q <= poll_tmo_q;
          end else if (link_evt.msg_start) begin
            state_q <= ST_RTS_WAIT;
            timer_q <= rts_send_q;
          end
        end
        ST_POLL_WAIT: begin
          if (link_evt.poll_rx) begin
            state_q <= ST_RTS_WAIT;
            timer_q <= rts_send_q;
          end else if (set_msg_err) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RTS_WAIT: begin
          if (timer_done) begin
            state_q <= ST_CTS_WAIT;
          end
        end
        ST_CTS_WAIT: begin
          if (link_evt.cts) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (link_evt.tx_done) begin
            state_q <= ST_RTS_HOLD;
            timer_q <= rts_off_q;
          end
        end
        ST_RTS_HOLD: begin
          if (timer_done) begin
            state_q <= ST_ACK_WAIT;
            timer_q <= ack_tmo_q;
          end
        end
        ST_ACK_WAIT: begin
          if (link_evt.ack_rx) begin
            state_q <= ST_IDLE;
          end else if (attempt_fail && set_undeliv) begin
            state_q <= ST_IDLE;
          end else if (attempt_fail) begin
            retry_cnt_q <= retry_cnt_q + 8'h01;
            nak_cnt_q <= 8'h00;
            enq_cnt_q <= 8'h00;
            state_q <= ST_RTS_WAIT;
            timer_q <= rts_send_q;
          end else if (link_evt.nak_rx) begin
            nak_cnt_q <= nak_cnt_q + 8'h01;
            state_q <= ST_RTS_WAIT;
            timer_q <= rts_send_q;
          end else if (tick_q && timer_q == 16'h0001 || timer_done) begin
            enq_cnt_q <= enq_cnt_q + 8'h01;
            timer_q <= ack_tmo_q;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // one-cycle send requests and line controls toward the framer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_ctl.rts <= 1'b0;
      link_ctl.pkt_send <= 1'b0;
      link_ctl.enq_send <= 1'b0;
      link_ctl.eot_send <= 1'b0;
      link_ctl.use_bcc <= 1'b0;
      link_ctl.embed_en <= 1'b0;
      link_ctl.undeliverable <= 1'b0;
      link_ctl.msg_error <= 1'b0;
    end else begin
      link_ctl.rts <= (state_q == ST_RTS_WAIT) || (state_q == ST_CTS_WAIT)
                      || (state_q == ST_SEND) || (state_q == ST_RTS_HOLD && !timer_done);
      link_ctl.pkt_send <= (state_q == ST_CTS_WAIT) && link_evt.cts;
      // enquiry goes out while an ack timeout still has budget
      link_ctl.enq_send <= (state_q == ST_ACK_WAIT) && !link_evt.ack_rx && !link_evt.nak_rx && !attempt_fail
                           && (tick_q && timer_q == 16'h0001 || timer_done);
      // empty poll answered only when suppression is off
      link_ctl.eot_send <= (state_q == ST_IDLE) && ctrl_q[CTRL_SLAVE_BIT] && link_evt.poll_rx
                           && !link_evt.msg_queued && !ctrl_q[CTRL_SUPPRESS_BIT];
      link_ctl.use_bcc <= ctrl_q[CTRL_BCC_BIT];
      link_ctl.embed_en <= ctrl_q[CTRL_EMBED_ALWAYS_BIT] || peer_embed_q;
      // sticky flags kept here so the output struct has one driver; a new event beats a status clear
      if (set_undeliv) begin
        link_ctl.undeliverable <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == OFS_STATUS && hwdata[STAT_UNDELIV_BIT]) begin
        link_ctl.undeliverable <= 1'b0;
      end
      if (set_msg_err) begin
        link_ctl.msg_error <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == OFS_STATUS && hwdata[STAT_MSG_ERR_BIT]) begin
        link_ctl.msg_error <= 1'b0;
      end
    end
  end

endmodule : link_retry_ctrl

// File: verilog/link_retry_pkg.sv
// package for the serial link retry and timing control block
// assumes one 10 mhz system clock and a 32-bit ahb-lite register bus
package link_retry_pkg;

  // clock and tick timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 20;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RETRY = 8'h04;
  localparam logic [7:0] OFS_ACK_TMO = 8'h08;
  localparam logic [7:0] OFS_POLL_TMO = 8'h0c;
  localparam logic [7:0] OFS_RTS_OFF = 8'h10;
  localparam logic [7:0] OFS_RTS_SEND = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // control register fields
  localparam int unsigned CTRL_BCC_BIT = 0;
  localparam int unsigned CTRL_EMBED_ALWAYS_BIT = 1;
  localparam int unsigned CTRL_SUPPRESS_BIT = 2;
  localparam int unsigned CTRL_SLAVE_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // retry register fields, 8 bits wide except the 7-bit transmit field
  localparam int unsigned RETRY_NAK_LSB = 0;
  localparam int unsigned RETRY_ENQ_LSB = 8;
  localparam int unsigned RETRY_TX_LSB = 16;
  localparam int unsigned RETRY_MSG_LSB = 24;
  localparam logic [7:0] NAK_RETRY_RESET = 8'h03;
  localparam logic [7:0] ENQ_RETRY_RESET = 8'h03;
  localparam logic [6:0] TX_RETRY_RESET = 7'h03;
  localparam logic [7:0] MSG_RETRY_RESET = 8'h03;

  // timeouts and delays in 20 ms ticks
  localparam logic [15:0] ACK_TMO_RESET = 16'h0032;
  localparam logic [15:0] POLL_TMO_RESET = 16'h0bb8;
  localparam logic [15:0] RTS_OFF_RESET = 16'h0000;
  localparam logic [15:0] RTS_SEND_RESET = 16'h0000;

  // status register fields
  localparam int unsigned STAT_UNDELIV_BIT = 0;
  localparam int unsigned STAT_MSG_ERR_BIT = 1;
  localparam int unsigned STAT_EMBED_BIT = 2;
  localparam int unsigned STAT_STATE_LSB = 8;

  // link sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_POLL_WAIT = 7'h02,
    ST_RTS_WAIT = 7'h04,
    ST_CTS_WAIT = 7'h08,
    ST_SEND = 7'h10,
    ST_RTS_HOLD = 7'h20,
    ST_ACK_WAIT = 7'h40
  } link_state_e;

  // events arriving from the serial side
  typedef struct packed {
    logic msg_start;
    logic msg_queued;
    logic tx_done;
    logic ack_rx;
    logic nak_rx;
    logic poll_rx;
    logic embed_seen;
    logic cts;
  } link_evt_s;

  // controls driven toward the serial side
  typedef struct packed {
    logic rts;
    logic pkt_send;
    logic enq_send;
    logic eot_send;
    logic use_bcc;
    logic embed_en;
    logic undeliverable;
    logic msg_error;
  } link_ctl_s;

endpackage : link_retry_pkg

// File: sim/link_retry_ctrl_props.sv
// port assertions for the link retry block
// assumes binding to link_retry_ctrl, one clock, async low reset
module link_retry_ctrl_props
  import link_retry_pkg::*;
#(
  parameter int unsigned TICK_LEN = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // serial link side
  input wire link_evt_s link_evt,
  input wire link_ctl_s link_ctl
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus never stalls and never errors
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stall or error");
  // link controls quiet right after reset
  property p_reset_quiet;
    $rose(hresetn) |-> link_ctl == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("link controls not quiet");
  // a packet only goes once rts stands and cts was seen
  property p_pkt_cts;
    link_ctl.pkt_send |-> link_ctl.rts && $past(link_evt.cts);
  endproperty
  a_pkt_cts: assert property (p_pkt_cts) else $error("packet without rts or cts");
  // a packet cannot go out in the cycle rts rises
  property p_rts_first;
    $rose(link_ctl.rts) |-> !link_ctl.pkt_send;
  endproperty
  a_rts_first: assert property (p_rts_first) else $error("packet as rts rises");
  // rts outlives the last character
  property p_rts_hold;
    link_evt.tx_done && link_ctl.rts |=> link_ctl.rts;
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("rts dropped with last character");
  // send strobe is a single cycle
  property p_pkt_pulse;
    link_ctl.pkt_send |=> !link_ctl.pkt_send;
  endproperty
  a_pkt_pulse: assert property (p_pkt_pulse) else $error("packet strobe too long");
  // enquiry goes out while waiting for ack, not mid packet
  property p_enq_quiet;
    link_ctl.enq_send |-> !link_ctl.rts && !link_ctl.pkt_send;
  endproperty
  a_enq_quiet: assert property (p_enq_quiet) else $error("enquiry during packet");
  // enquiries are at least nine cycles apart
  property p_enq_gap;
    link_ctl.enq_send |=> !link_ctl.enq_send [*8];
  endproperty
  a_enq_gap: assert property (p_enq_gap) else $error("enquiries too close");
  // empty poll reply only follows a poll with nothing queued
  property p_eot_cause;
    link_ctl.eot_send |-> $past(link_evt.poll_rx) && !$past(link_evt.msg_queued);
  endproperty
  a_eot_cause: assert property (p_eot_cause) else $error("empty poll reply without cause");

  c_pkt: cover property (link_ctl.pkt_send);
  c_enq: cover property (link_ctl.enq_send);
  c_eot: cover property (link_ctl.eot_send);
endmodule : link_retry_ctrl_props

bind link_retry_ctrl link_retry_ctrl_props #(.TICK_LEN(TICK_LEN)) link_retry_ctrl_props_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .link_evt(link_evt), .link_ctl(link_ctl));

// File: sim/link_peer.sv
// modem plus far station, as seen from the block's serial side
// assumes hclk-synchronous events; knobs come from the bench
module link_peer
  import link_retry_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // block controls and bench knobs
  input wire link_ctl_s link_ctl,
  input wire logic [1:0] reply,
  input wire logic [3:0] cts_lag,
  input wire logic poll_on,
  // answers toward the block
  output logic cts,
  output logic tx_done,
  output logic ack_rx,
  output logic nak_rx,
  output logic poll_rx
);
  logic [3:0] lag_q;
  logic [2:0] tx_q;
  logic [2:0] rsp_q;
  logic [2:0] poll_q;

  // cts lags rts, so a send delay is really needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts <= 1'b0;
      lag_q <= 4'h0;
    end else if (!link_ctl.rts) begin
      cts <= 1'b0;
      lag_q <= 4'h0;
    end else if (lag_q >= cts_lag) begin
      cts <= 1'b1;
    end else begin
      lag_q <= lag_q + 4'h1;
    end
  end

  // packet drains, then ack, nak or silence (reply 0, 1, 2)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q <= 3'h0;
      rsp_q <= 3'h0;
      tx_done <= 1'b0;
      ack_rx <= 1'b0;
      nak_rx <= 1'b0;
    end else begin
      if (link_ctl.pkt_send) tx_q <= 3'h4;
      else if (tx_q != 3'h0) tx_q <= tx_q - 3'h1;
      if (tx_done) rsp_q <= 3'h3;
      else if (rsp_q != 3'h0) rsp_q <= rsp_q - 3'h1;
      tx_done <= tx_q == 3'h1;
      ack_rx <= rsp_q == 3'h1 && reply == 2'h0;
      nak_rx <= rsp_q == 3'h1 && reply == 2'h1;
    end
  end

  // master station polls every eight cycles when enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poll_q <= 3'h0;
      poll_rx <= 1'b0;
    end else begin
      poll_q <= poll_q + 3'h1;
      poll_rx <= poll_on && poll_q == 3'h0;
    end
  end
endmodule : link_peer

// File: sim/serial_link_retry_timing_control_test.sv
// self-checking bench for the link retry block
// assumes link_peer as far side and a 10 mhz hclk; tick shortened to 10 cycles
module serial_link_retry_timing_control_test
  import link_retry_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic msg_start, msg_queued, embed_seen, poll_on, rts_d;
  logic cts, tx_done, ack_rx, nak_rx, poll_rx;
  logic [1:0] reply;
  logic [3:0] cts_lag;
  link_ctl_s link_ctl;
  int error_cnt, check_count, n_pkt, n_enq, n_eot, n_poll, cyc, t_rts, t_tx, gap_send, gap_off, gap_enq;

  link_retry_ctrl #(.TICK_LEN(10)) link_retry_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .link_evt({msg_start, msg_queued, tx_done, ack_rx, nak_rx, poll_rx, embed_seen, cts}), .link_ctl(link_ctl));
  link_peer link_peer_inst (.hclk(hclk), .hresetn(hresetn), .link_ctl(link_ctl), .reply(reply),
    .cts_lag(cts_lag), .poll_on(poll_on), .cts(cts), .tx_done(tx_done), .ack_rx(ack_rx), .nak_rx(nak_rx),
    .poll_rx(poll_rx));

  // 100 ns clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // event counts and intervals, sampled before the edge's updates
  always @(posedge hclk) begin
    cyc++;
    if (link_ctl.rts === 1'b1 && rts_d === 1'b0) t_rts = cyc;
    if (link_ctl.rts === 1'b0 && rts_d === 1'b1) gap_off = cyc - t_tx;
    if (link_ctl.pkt_send === 1'b1) begin
      n_pkt++;
      gap_send = cyc - t_rts;
    end
    if (link_ctl.enq_send === 1'b1) begin
      if (n_enq == 0) gap_enq = cyc - t_tx;
      n_enq++;
    end
    if (link_ctl.eot_send === 1'b1) n_eot++;
    if (poll_rx === 1'b1) n_poll++;
    if (tx_done === 1'b1) t_tx = cyc;
    rts_d = link_ctl.rts;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_rdy

  // one single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rd

  // start a message and wait until the sequencer is idle again
  task automatic send_msg;
    logic [31:0] q;
    int n;
    msg_start <= 1'b1;
    @(posedge hclk);
    msg_start <= 1'b0;
    n = 0;
    do begin
      bus(OFS_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[14:8] !== ST_IDLE && n < 300);
    if (q[14:8] !== ST_IDLE) begin
      error_cnt++;
      print_verdict();
    end
  endtask : send_msg

  // watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {msg_start, msg_queued, embed_seen, poll_on, reply, cts_lag} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CTRL, 32'(CTRL_RESET), '1, "ctrl");
    rd(OFS_RETRY, {MSG_RETRY_RESET, 1'b0, TX_RETRY_RESET, ENQ_RETRY_RESET, NAK_RETRY_RESET}, '1, "retry");
    rd(OFS_ACK_TMO, 32'(ACK_TMO_RESET), '1, "ack tmo");
    rd(OFS_POLL_TMO, 32'(POLL_TMO_RESET), '1, "poll tmo");
    rd(OFS_RTS_OFF, 32'(RTS_OFF_RESET), '1, "rts off");
    rd(OFS_RTS_SEND, 32'(RTS_SEND_RESET), '1, "rts send");
    rd(8'h1c, 32'h0, '1, "unmapped");
    chk("crc default", 0, link_ctl.use_bcc);
    chk("embed default", 0, link_ctl.embed_en);
    wr(OFS_CTRL, 32'h3);
    repeat (2) @(posedge hclk);
    chk("bcc", 1, link_ctl.use_bcc);
    chk("embed always", 1, link_ctl.embed_en);
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("embed off", 0, link_ctl.embed_en);
    embed_seen <= 1'b1;
    @(posedge hclk);
    embed_seen <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("embed after peer", 1, link_ctl.embed_en);
    $display("test options done");
    // acked, nak'd, then silent master sends
    send_msg();
    chk("acked packets", 1, n_pkt);
    wr(OFS_RETRY, 32'h00010101);
    reply <= 2'h1;
    n_pkt = 0;
    send_msg();
    chk("nak packets", 4, n_pkt);
    rd(OFS_STATUS, 32'h1, 32'h1, "nak undeliverable");
    wr(OFS_STATUS, 32'h3);
    wr(OFS_RETRY, 32'h00000200);
    wr(OFS_ACK_TMO, 32'h2);
    reply <= 2'h2;
    n_pkt = 0;
    send_msg();
    chk("no retry packets", 1, n_pkt);
    chk("enquiries", 2, n_enq);
    chk("ack wait", 1, gap_enq inside {[11:25]});
    rd(OFS_STATUS, 32'h1, 32'h1, "silent undeliverable");
    wr(OFS_STATUS, 32'h3);
    // modem delays with a slow cts
    wr(OFS_RETRY, 32'h0);
    wr(OFS_RTS_SEND, 32'h2);
    wr(OFS_RTS_OFF, 32'h2);
    cts_lag <= 4'h3;
    send_msg();
    chk("send delay", 1, gap_send inside {[11:25]});
    chk("off delay", 1, gap_off inside {[11:25]});
    wr(OFS_RTS_SEND, 32'h0);
    wr(OFS_RTS_OFF, 32'h0);
    wr(OFS_STATUS, 32'h3);
    $display("test master done");
    // slave polls, with and without suppression
    wr(OFS_CTRL, 32'h8);
    poll_on <= 1'b1;
    repeat (40) @(posedge hclk);
    poll_on <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("empty poll replies", n_poll, n_eot);
    n_eot = 0;
    wr(OFS_CTRL, 32'hc);
    poll_on <= 1'b1;
    repeat (40) @(posedge hclk);
    poll_on <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("suppressed replies", 0, n_eot);
    // slave message: poll timeout, disabled timeout, retries
    wr(OFS_CTRL, 32'h8);
    wr(OFS_POLL_TMO, 32'h2);
    msg_queued <= 1'b1;
    msg_start <= 1'b1;
    @(posedge hclk);
    msg_start <= 1'b0;
    repeat (40) @(posedge hclk);
    rd(OFS_STATUS, 32'h2, 32'h2, "poll timeout");
    wr(OFS_STATUS, 32'h3);
    wr(OFS_POLL_TMO, 32'h0);
    msg_start <= 1'b1;
    @(posedge hclk);
    msg_start <= 1'b0;
    repeat (60) @(posedge hclk);
    rd(OFS_STATUS, 32'h0, 32'h2, "no timeout at zero");
    reply <= 2'h0;
    poll_on <= 1'b1;
    send_msg();
    wr(OFS_RETRY, 32'h01000000);
    reply <= 2'h2;
    n_pkt = 0;
    send_msg();
    chk("slave retries", 2, n_pkt);
    rd(OFS_STATUS, 32'h1, 32'h1, "slave undeliverable");
    $display("test slave done");
    print_verdict();
  end
endmodule : serial_link_retry_timing_control_test
